// File: rtl/typeb_map.svh
`ifndef TYPEB_MAP_SVH
`define TYPEB_MAP_SVH

// Block control byte codings, without CID and NAD
`define TB_I_BASE 8'h02
`define TB_R_BASE 8'ha2
`define TB_S_DESEL 8'hc2
`define TB_S_WTX 8'hf2
`define TB_CHAIN_BIT 4
`define TB_NAK_BIT 4
`define TB_NUM_BIT 0

// Block numbers loaded at activation
`define TB_TAG_BLK_INIT 1'b1
`define TB_RW_BLK_INIT 1'b0

// Family identifier wildcard
`define TB_AFI_ANY 8'h00

// Chained block payload and message store size
`define TB_CHUNK 9'd64
`define TB_MEM_DEPTH 256

// Frame wait time unit in us and clock rate in MHz
`define TB_FWT_US 302
`define TB_CLK_MHZ 200

// Error replies tried before the reader gives up
`define TB_RETRY_MAX 2'd3

`endif

// File: rtl/typeb_pkg.sv
`include "typeb_map.svh"

package typeb_pkg;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_RXPCB = 3'b001,
    T_RXINF = 3'b010,
    T_REPLY = 3'b011,
    T_APP = 3'b100,
    T_TXPCB = 3'b101,
    T_TXINF = 3'b110,
    T_HALT = 3'b111
  } tag_state_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_LOAD = 3'b001,
    P_SEND = 3'b010,
    P_TXPCB = 3'b011,
    P_TXINF = 3'b100,
    P_WAIT = 3'b101,
    P_RXINF = 3'b110
  } rw_state_t;

  // Information block control byte
  function automatic logic is_i(input logic [7:0] p);
    return (p[7:5] == 3'b000) && (p[3:1] == 3'b001);
  endfunction : is_i

  // Receive-ready block control byte
  function automatic logic is_r(input logic [7:0] p);
    return (p[7:5] == 3'b101) && (p[3:1] == 3'b001);
  endfunction : is_r

  function automatic logic [7:0] i_pcb(input logic c, input logic n);
    return `TB_I_BASE | (8'(c) << `TB_CHAIN_BIT) | 8'(n);
  endfunction : i_pcb

  function automatic logic [7:0] r_pcb(input logic nak, input logic n);
    return `TB_R_BASE | (8'(nak) << `TB_NAK_BIT) | 8'(n);
  endfunction : r_pcb

  // Family filter for the request command
  function automatic logic afi_match(input logic [7:0] req,
                                     input logic [7:0] sto);
    if (req == `TB_AFI_ANY) begin
      return 1'b1;
    end else if (req[3:0] == 4'h0) begin
      return req[7:4] == sto[7:4];
    end else if (req[7:4] == 4'h0) begin
      return req[3:0] == sto[3:0];
    end else begin
      return req == sto;
    end
  endfunction : afi_match

endpackage : typeb_pkg

// File: rtl/typeb_link_if.sv
interface typeb_link_if ();
  logic activate;
  logic reqb_valid;
  logic [7:0] reqb_afi;
  logic atqb;
  logic dn_valid;
  logic dn_ready;
  logic dn_last;
  logic [7:0] dn_data;
  logic up_valid;
  logic up_ready;
  logic up_last;
  logic [7:0] up_data;

  modport reader (
    output activate, reqb_valid, reqb_afi, dn_valid, dn_last, dn_data,
    output up_ready,
    input atqb, dn_ready, up_valid, up_last, up_data
  );

  modport tag (
    input activate, reqb_valid, reqb_afi, dn_valid, dn_last, dn_data,
    input up_ready,
    output atqb, dn_ready, up_valid, up_last, up_data
  );
endinterface : typeb_link_if

// File: rtl/typeb_tag_end.sv
// Overview of operation
// - Reader starts its block number at zero.
// - Reader toggles number on matching I/ACK.
// - Tag loads block number one on activation.
// - Tag toggles number on every I-block.
// - ACK with other number toggles; NAK keeps. Tag toggles on it only while chaining.
// - Tag only replies, never opens exchanges.
// - Chained I-block is answered with ACK.
// - Only DESELECT supported; always answered.
// - Illegal block or timeout gets NAK.
// - While tag chains, errors get ACK instead.
// - Reader resends I-block on mismatched ACK.
// - Reader continues chain on matching ACK.
// - Unanswered DESELECT repeated or tag dropped.
// - Tag never sends wait-time-extension blocks.
// - Unchained I-block gets an affirmative answer.
// - R-block with equal number: resend I-block.
// - NAK with other number gets ACK.
// - ACK with other number sends next chunk.
// - Command header, optional length and data.
// - Optional expected-length byte ends command.
// - APDUs ride in INF; response ends SW1 SW2.
// - Stored family identifier gates REQB answers.
// - Zero, nibble or exact family matching.
`include "typeb_map.svh"
module typeb_tag_end
  import typeb_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  typeb_link_if.tag link,
  input wire logic [7:0] sys_afi_i,
  output logic cmd_valid_o,
  input wire logic cmd_ready_i,
  output logic [7:0] cmd_data_o,
  output logic cmd_last_o,
  input wire logic resp_valid_i,
  output logic resp_ready_o,
  input wire logic [7:0] resp_data_i,
  input wire logic resp_last_i,
  output logic active_o,
  output logic chain_o
);
  tag_state_t st_r, st_nxt;
  logic blk_r, chain_r, inf_r, fwd_r, chn_in_r, app_r, halt_r, atqb_r;
  logic [7:0] pcb_r, tx_data_r, d_pcb;
  logic [8:0] len_r, off_r, idx_r;
  logic [7:0] mem [0:`TB_MEM_DEPTH-1];
  logic [8:0] buf_q [0:1];
  logic wp_r, rp_r;
  logic [1:0] cnt_r;
  logic d_inf, d_tog, d_adv, d_fwd, d_app, d_halt;
  // Handshakes and offsets of the stored reply
  wire dn_fire = link.dn_valid & link.dn_ready;
  wire up_fire = link.up_valid & link.up_ready;
  wire rsp_fire = resp_valid_i & resp_ready_o;
  wire [7:0] pcb = link.dn_data;
  wire r_eq = pcb[`TB_NUM_BIT] == blk_r;
  wire r_nak = pcb[`TB_NAK_BIT];
  wire [8:0] rem = len_r - off_r;
  wire [8:0] nxt_off = off_r + `TB_CHUNK;
  wire [8:0] rem2 = len_r - nxt_off;
  wire more = rem > `TB_CHUNK;
  wire more2 = rem2 > `TB_CHUNK;
  wire [8:0] chunk_n = more ? `TB_CHUNK : rem;
  wire tx_end = idx_r == (chunk_n - 9'd1);
  wire [7:0] rd_addr0 = off_r[7:0];
  wire [7:0] rd_addrn = off_r[7:0] + idx_r[7:0] + 8'd1;
  wire active = (st_r != T_IDLE) && (st_r != T_HALT);
  wire buf_full = cnt_r == 2'd2;
  wire push = dn_fire && (st_r == T_RXINF) && fwd_r;
  wire pop = cmd_valid_o & cmd_ready_i;
  // Link side drive; tag speaks only in its transmit states
  assign link.up_valid = (st_r == T_TXPCB) || (st_r == T_TXINF);
  assign link.up_data = tx_data_r;
  assign link.up_last = (st_r == T_TXPCB) ? !inf_r : tx_end;
  assign link.dn_ready = (st_r == T_RXINF) ? !(fwd_r && buf_full) :
                         (st_r != T_REPLY) && (st_r != T_APP) &&
                         (st_r != T_TXPCB) && (st_r != T_TXINF);
  assign link.atqb = atqb_r;
  assign resp_ready_o = st_r == T_APP;
  assign cmd_valid_o = cnt_r != 2'd0;
  assign cmd_data_o = buf_q[rp_r][7:0];
  assign cmd_last_o = buf_q[rp_r][8];
  assign active_o = active;
  assign chain_o = chain_r;
  // Reply choice for the received control byte; never a WTX
  always_comb begin
    d_pcb = r_pcb(~chain_r, blk_r);
    d_inf = 1'b0;
    d_tog = 1'b0;
    d_adv = 1'b0;
    d_fwd = 1'b0;
    d_app = 1'b0;
    d_halt = 1'b0;
    if (is_i(pcb)) begin
      d_tog = 1'b1;
      d_fwd = 1'b1;
      d_pcb = r_pcb(1'b0, ~blk_r);
      d_app = ~pcb[`TB_CHAIN_BIT];
    end else if (is_r(pcb) && r_eq) begin
      d_inf = len_r != 9'd0;
      d_pcb = i_pcb(more, blk_r);
    end else if (is_r(pcb) && r_nak) begin
      d_pcb = r_pcb(1'b0, blk_r);
    end else if (is_r(pcb) && chain_r) begin
      d_tog = 1'b1;
      d_adv = 1'b1;
      d_inf = 1'b1;
      d_pcb = i_pcb(more2, ~blk_r);
    end else if (pcb == `TB_S_DESEL) begin
      d_pcb = `TB_S_DESEL;
      d_halt = 1'b1;
    end
  end
  // Next state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      T_RXPCB: begin
        if (dn_fire) begin
          st_nxt = link.dn_last ? T_REPLY : T_RXINF;
        end
      end
      T_RXINF: begin
        if (dn_fire && link.dn_last) begin
          st_nxt = T_REPLY;
        end
      end
      T_REPLY: st_nxt = app_r ? T_APP : T_TXPCB;
      T_APP: begin
        if (rsp_fire && resp_last_i) begin
          st_nxt = T_REPLY;
        end
      end
      T_TXPCB: begin
        if (up_fire) begin
          st_nxt = inf_r ? T_TXINF : (halt_r ? T_HALT : T_RXPCB);
        end
      end
      T_TXINF: begin
        if (up_fire && tx_end) begin
          st_nxt = T_RXPCB;
        end
      end
      default: st_nxt = st_r;
    endcase
    if (link.activate) begin
      st_nxt = T_RXPCB;
    end
  end
  // Block numbering, chaining and transmit control
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= T_IDLE;
      blk_r <= `TB_TAG_BLK_INIT;
      chain_r <= 1'b0;
      pcb_r <= 8'h00;
      inf_r <= 1'b0;
      fwd_r <= 1'b0;
      chn_in_r <= 1'b0;
      app_r <= 1'b0;
      halt_r <= 1'b0;
      len_r <= 9'h000;
      off_r <= 9'h000;
      idx_r <= 9'h000;
      tx_data_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      if (link.activate) begin
        blk_r <= `TB_TAG_BLK_INIT;
        chain_r <= 1'b0;
        len_r <= 9'h000;
        off_r <= 9'h000;
        app_r <= 1'b0;
        halt_r <= 1'b0;
      end else begin
        case (st_r)
          T_RXPCB: begin
            if (dn_fire) begin
              pcb_r <= d_pcb;
              inf_r <= d_inf;
              fwd_r <= d_fwd;
              chn_in_r <= pcb[`TB_CHAIN_BIT];
              app_r <= d_app;
              halt_r <= d_halt;
              if (d_tog) begin
                blk_r <= ~blk_r;
              end
              if (d_adv) begin
                off_r <= nxt_off;
              end
            end
          end
          T_REPLY: begin
            tx_data_r <= pcb_r;
            idx_r <= 9'h000;
            if (!app_r && inf_r) begin
              chain_r <= pcb_r[`TB_CHAIN_BIT];
            end
          end
          T_APP: begin
            if (rsp_fire) begin
              idx_r <= idx_r + 9'd1;
            end
            if (rsp_fire && resp_last_i) begin
              len_r <= idx_r + 9'd1;
              off_r <= 9'h000;
              app_r <= 1'b0;
              inf_r <= 1'b1;
              pcb_r <= i_pcb(idx_r >= `TB_CHUNK, blk_r);
            end
          end
          T_TXPCB: begin
            if (up_fire) begin
              tx_data_r <= mem[rd_addr0];
              idx_r <= 9'h000;
              if (halt_r) begin
                chain_r <= 1'b0;
              end
            end
          end
          T_TXINF: begin
            if (up_fire) begin
              idx_r <= idx_r + 9'd1;
              tx_data_r <= mem[rd_addrn];
            end
          end
          default: idx_r <= idx_r;
        endcase
      end
    end
  end
  // Request filter answer, only while not in a session
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      atqb_r <= 1'b0;
    end else begin
      atqb_r <= link.reqb_valid && !active &&
                afi_match(link.reqb_afi, sys_afi_i);
    end
  end
  // Response store for resending and chaining
  always_ff @(posedge mclk_i) begin
    if (rsp_fire) begin
      mem[idx_r[7:0]] <= resp_data_i;
    end
  end
  // Two-entry command buffer toward the application
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
  // Buffer storage; last marks the end of an unchained command
  always_ff @(posedge mclk_i) begin
    if (push) begin
      buf_q[wp_r] <= {link.dn_last & ~chn_in_r, link.dn_data};
    end
  end
endmodule : typeb_tag_end

// File: rtl/typeb_rw_end.sv
`include "typeb_map.svh"

module typeb_rw_end
  import typeb_pkg::*;
#(
  parameter logic [23:0] FWT_CYC = 24'(`TB_FWT_US * `TB_CLK_MHZ)
)(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  typeb_link_if.reader link,
  input wire logic activate_i,
  input wire logic reqb_i,
  input wire logic [7:0] reqb_afi_i,
  output logic atqb_o,
  input wire logic deselect_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_data_i,
  input wire logic cmd_last_i,
  output logic resp_valid_o,
  output logic [7:0] resp_data_o,
  output logic resp_last_o,
  output logic busy_o,
  output logic fail_o
);

  rw_state_t st_r;
  logic blk_r;
  logic tchain_r;
  logic desel_r;
  logic [7:0] pcb_r;
  logic inf_r;
  logic fwd_r;
  logic chn_in_r;
  logic go_r;
  logic fail_r;
  logic act_r;
  logic reqb_r;
  logic [7:0] afi_r;
  logic [1:0] retry_r;
  logic [23:0] tmr_r;
  logic [8:0] len_r;
  logic [8:0] off_r;
  logic [8:0] idx_r;
  logic [7:0] tx_data_r;
  logic rv_r;
  logic [7:0] rd_r;
  logic rl_r;
  logic [7:0] mem [0:`TB_MEM_DEPTH-1];
  logic [7:0] d_pcb;
  logic d_err;
  logic d_go;
  logic d_inf;
  logic d_tog;
  logic d_adv;

  // Handshakes, offsets and the error reply
  wire dn_fire = link.dn_valid & link.dn_ready;
  wire up_fire = link.up_valid & link.up_ready;
  wire cmd_fire = cmd_valid_i & cmd_ready_o;
  wire [7:0] pcb = link.up_data;
  wire eq = pcb[`TB_NUM_BIT] == blk_r;
  wire [8:0] rem = len_r - off_r;
  wire [8:0] nxt_off = off_r + `TB_CHUNK;
  wire [8:0] rem2 = len_r - nxt_off;
  wire more = rem > `TB_CHUNK;
  wire more2 = rem2 > `TB_CHUNK;
  wire [8:0] chunk_n = more ? `TB_CHUNK : rem;
  wire tx_end = idx_r == (chunk_n - 9'd1);
  wire timeout = (st_r == P_WAIT) && !up_fire && (tmr_r == FWT_CYC - 24'd1);
  wire give_up = retry_r == `TB_RETRY_MAX;
  wire [7:0] err_pcb = desel_r ? `TB_S_DESEL : r_pcb(~tchain_r, blk_r);

  assign link.activate = act_r;
  assign link.reqb_valid = reqb_r;
  assign link.reqb_afi = afi_r;
  assign link.dn_valid = (st_r == P_TXPCB) || (st_r == P_TXINF);
  assign link.dn_data = tx_data_r;
  assign link.dn_last = (st_r == P_TXPCB) ? !inf_r : tx_end;
  assign link.up_ready = (st_r == P_WAIT) || (st_r == P_RXINF);
  assign atqb_o = link.atqb;
  assign cmd_ready_o = st_r == P_LOAD;
  assign resp_valid_o = rv_r;
  assign resp_data_o = rd_r;
  assign resp_last_o = rl_r;
  assign busy_o = st_r != P_IDLE;
  assign fail_o = fail_r;

  // Reply choice for a block from the tag
  always_comb begin
    d_pcb = err_pcb;
    d_err = 1'b1;
    d_go = 1'b1;
    d_inf = 1'b0;
    d_tog = 1'b0;
    d_adv = 1'b0;
    if (desel_r) begin
      if (pcb == `TB_S_DESEL) begin
        d_err = 1'b0;
        d_go = 1'b0;
      end
    end else if (is_i(pcb)) begin
      d_err = 1'b0;
      d_tog = eq;
      d_go = pcb[`TB_CHAIN_BIT];
      d_pcb = r_pcb(1'b0, eq ? ~blk_r : blk_r);
    end else if (is_r(pcb) && !pcb[`TB_NAK_BIT] && !eq) begin
      d_err = 1'b0;
      d_inf = 1'b1;
      d_pcb = i_pcb(more, blk_r);
    end else if (is_r(pcb) && !pcb[`TB_NAK_BIT] && more) begin
      d_err = 1'b0;
      d_tog = 1'b1;
      d_adv = 1'b1;
      d_inf = 1'b1;
      d_pcb = i_pcb(more2, ~blk_r);
    end
  end

  // Exchange sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= P_IDLE;
      blk_r <= `TB_RW_BLK_INIT;
      tchain_r <= 1'b0;
      desel_r <= 1'b0;
      pcb_r <= 8'h00;
      inf_r <= 1'b0;
      fwd_r <= 1'b0;
      chn_in_r <= 1'b0;
      go_r <= 1'b0;
      fail_r <= 1'b0;
      retry_r <= 2'd0;
      tmr_r <= 24'h000000;
      len_r <= 9'h000;
      off_r <= 9'h000;
      idx_r <= 9'h000;
      tx_data_r <= 8'h00;
    end else if (activate_i) begin
      st_r <= P_IDLE;
      blk_r <= `TB_RW_BLK_INIT;
      tchain_r <= 1'b0;
      desel_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      case (st_r)
        P_IDLE: begin
          idx_r <= 9'h000;
          retry_r <= 2'd0;
          if (deselect_i) begin
            pcb_r <= `TB_S_DESEL;
            inf_r <= 1'b0;
            desel_r <= 1'b1;
            st_r <= P_SEND;
          end else if (cmd_valid_i) begin
            st_r <= P_LOAD;
          end
        end
        P_LOAD: begin
          if (cmd_fire) begin
            idx_r <= idx_r + 9'd1;
          end
          if (cmd_fire && cmd_last_i) begin
            len_r <= idx_r + 9'd1;
            off_r <= 9'h000;
            inf_r <= 1'b1;
            pcb_r <= i_pcb(idx_r >= `TB_CHUNK, blk_r);
            st_r <= P_SEND;
          end
        end
        P_SEND: begin
          tx_data_r <= pcb_r;
          idx_r <= 9'h000;
          st_r <= P_TXPCB;
        end
        P_TXPCB: begin
          if (dn_fire) begin
            tx_data_r <= mem[off_r[7:0]];
            tmr_r <= 24'h000000;
            st_r <= inf_r ? P_TXINF : P_WAIT;
          end
        end
        P_TXINF: begin
          if (dn_fire) begin
            idx_r <= idx_r + 9'd1;
            tx_data_r <= mem[off_r[7:0] + idx_r[7:0] + 8'd1];
            tmr_r <= 24'h000000;
            st_r <= tx_end ? P_WAIT : P_TXINF;
          end
        end
        P_WAIT: begin
          tmr_r <= tmr_r + 24'd1;
          if (timeout) begin
            pcb_r <= err_pcb;
            inf_r <= 1'b0;
            retry_r <= retry_r + 2'd1;
            fail_r <= give_up;
            st_r <= give_up ? P_IDLE : P_SEND;
          end else if (up_fire) begin
            pcb_r <= d_pcb;
            inf_r <= d_inf;
            fwd_r <= is_i(pcb) && !d_err;
            chn_in_r <= pcb[`TB_CHAIN_BIT];
            go_r <= d_go && !(d_err && give_up);
            retry_r <= d_err ? retry_r + 2'd1 : 2'd0;
            fail_r <= d_err && give_up;
            if (is_i(pcb) && !d_err) begin
              tchain_r <= pcb[`TB_CHAIN_BIT];
            end
            if (!d_err && !d_go) begin
              desel_r <= 1'b0;
            end
            if (d_tog) begin
              blk_r <= ~blk_r;
            end
            if (d_adv) begin
              off_r <= nxt_off;
            end
            if (link.up_last) begin
              st_r <= (d_go && !(d_err && give_up)) ? P_SEND : P_IDLE;
            end else begin
              st_r <= P_RXINF;
            end
          end
        end
        P_RXINF: begin
          if (up_fire && link.up_last) begin
            st_r <= go_r ? P_SEND : P_IDLE;
          end
        end
        default: st_r <= P_IDLE;
      endcase
    end
  end

  // Request pulse, response bytes and activation strobe
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      act_r <= 1'b0;
      reqb_r <= 1'b0;
      afi_r <= 8'h00;
      rv_r <= 1'b0;
      rd_r <= 8'h00;
      rl_r <= 1'b0;
    end else begin
      act_r <= activate_i;
      reqb_r <= reqb_i;
      afi_r <= reqb_i ? reqb_afi_i : afi_r;
      rv_r <= up_fire && (st_r == P_RXINF) && fwd_r;
      rd_r <= link.up_data;
      rl_r <= link.up_last & ~chn_in_r;
    end
  end

  // Command store for resending and chaining
  always_ff @(posedge mclk_i) begin
    if (cmd_fire) begin
      mem[idx_r[7:0]] <= cmd_data_i;
    end
  end

endmodule : typeb_rw_end

// File: verif/typeb_link_monitor.sv
`include "typeb_map.svh"

module typeb_link_monitor (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reqb_valid,
  input wire logic atqb,
  input wire logic dn_valid,
  input wire logic dn_ready,
  input wire logic dn_last,
  input wire logic [7:0] dn_data,
  input wire logic up_valid,
  input wire logic up_ready,
  input wire logic up_last,
  input wire logic [7:0] up_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic dn_first_r, up_first_r, asked_r, rx_i_r, rx_num_r;
  logic [7:0] pcb_r;

  // Frame position decode
  wire dn_take = dn_valid && dn_ready;
  wire up_take = up_valid && up_ready;
  wire [7:0] dn_pcb = dn_first_r ? dn_data : pcb_r;
  wire dn_end = dn_take && dn_last;
  wire up_head = up_valid && up_first_r;
  wire plain_i = (dn_pcb[7:5] == 3'b000) && !dn_pcb[4];

  // Tracks frame heads and the request still owed a reply
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dn_first_r <= 1'b1;
      up_first_r <= 1'b1;
      asked_r <= 1'b0;
      rx_i_r <= 1'b0;
      rx_num_r <= 1'b0;
      pcb_r <= 8'h00;
    end else begin
      if (dn_take) dn_first_r <= dn_last;
      if (dn_take && dn_first_r) pcb_r <= dn_data;
      if (up_take) up_first_r <= up_last;
      if (dn_end) begin
        asked_r <= 1'b1;
        rx_i_r <= plain_i;
        rx_num_r <= dn_pcb[0];
      end else if (up_take && up_last) begin
        asked_r <= 1'b0;
        rx_i_r <= 1'b0;
      end
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_desel_in;
    dn_end && (dn_pcb == `TB_S_DESEL);
  endsequence
  sequence s_chain_in;
    dn_end && (dn_pcb[7:5] == 3'b000) && dn_pcb[4];
  endsequence
  sequence s_ack_out;
    up_head && ((up_data & 8'hfe) == `TB_R_BASE);
  endsequence

  // Protocol checks on the shared link
  a_reply_only_asked:
    assert property (up_valid |-> asked_r) else $error("unasked reply");
  a_no_wait_ext:
    assert property (up_head |-> up_data != `TB_S_WTX)
      else $error("wait extension sent");
  a_desel_answered:
    assert property (s_desel_in |-> ##[1:4] (up_head && up_data == `TB_S_DESEL))
      else $error("deselect unanswered");
  a_chain_acked:
    assert property (s_chain_in |-> ##[1:4] s_ack_out)
      else $error("chained block not acked");
  a_reply_number:
    assert property (up_head && rx_i_r |->
      (up_data[7:5] == 3'b000) && (up_data[0] == rx_num_r))
      else $error("reply block number wrong");
  a_atqb_cause:
    assert property (atqb |-> $past(reqb_valid)) else $error("atqb uncaused");
  a_dn_hold:
    assert property (dn_valid && !dn_ready |=>
      dn_valid && $stable(dn_data) && $stable(dn_last))
      else $error("down byte dropped");
  a_up_hold:
    assert property (up_valid && !up_ready |=>
      up_valid && $stable(up_data) && $stable(up_last))
      else $error("up byte dropped");
endmodule : typeb_link_monitor

// File: verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic act, reqb, desel, cvalid, clast, rvalid, rlast;
  logic cmd_rdy = 1'b0;
  logic [7:0] tick = 8'h00;
  logic [7:0] rafi, cdata, rdata, sys_afi, rsp_d, tcd;
  logic atqb, cready, rsp_v, rsp_last, busy, fail, tcv, tcl, active;
  logic trdy, trdy2, chain2;
  int fail_count = 0;
  int checked = 0;
  typeb_link_if lk ();
  typeb_link_if lk2 ();

  typeb_rw_end #(.FWT_CYC(24'd300)) typeb_rw_end_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(lk.reader),
    .activate_i(act), .reqb_i(reqb), .reqb_afi_i(rafi), .atqb_o(atqb),
    .deselect_i(desel), .cmd_valid_i(cvalid), .cmd_ready_o(cready),
    .cmd_data_i(cdata), .cmd_last_i(clast), .resp_valid_o(rsp_v),
    .resp_data_o(rsp_d), .resp_last_o(rsp_last), .busy_o(busy),
    .fail_o(fail));
  typeb_tag_end typeb_tag_end_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(lk.tag), .sys_afi_i(sys_afi),
    .cmd_valid_o(tcv), .cmd_ready_i(cmd_rdy), .cmd_data_o(tcd),
    .cmd_last_o(tcl), .resp_valid_i(rvalid), .resp_ready_o(trdy),
    .resp_data_i(rdata), .resp_last_i(rlast), .active_o(active),
    .chain_o());
  // Second tag, driven raw by the bench
  typeb_tag_end typeb_tag_end_inst_b (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(lk2.tag), .sys_afi_i(sys_afi),
    .cmd_valid_o(), .cmd_ready_i(cmd_rdy), .cmd_data_o(), .cmd_last_o(),
    .resp_valid_i(rvalid), .resp_ready_o(trdy2), .resp_data_i(rdata),
    .resp_last_i(rlast), .active_o(), .chain_o(chain2));
  typeb_link_monitor typeb_link_monitor_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reqb_valid(lk.reqb_valid),
    .atqb(lk.atqb), .dn_valid(lk.dn_valid), .dn_ready(lk.dn_ready),
    .dn_last(lk.dn_last), .dn_data(lk.dn_data), .up_valid(lk.up_valid),
    .up_ready(lk.up_ready), .up_last(lk.up_last), .up_data(lk.up_data));

  initial begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Command sink stalls four cycles in sixteen
  always @(posedge mclk_i) begin
    tick <= tick + 8'h01;
    cmd_rdy <= tick[3:2] != 2'b11;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc

  task automatic chk(input string what, input logic [31:0] exp, got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic t_reqb;
    logic [8:0] tbl [7] = '{9'h100, 9'h130, 9'h040, 9'h105, 9'h003,
                            9'h135, 9'h036};
    logic seen;
    for (int i = 0; i < 7; i++) begin
      rafi <= tbl[i][7:0];
      reqb <= 1'b1;
      cyc(1);
      reqb <= 1'b0;
      seen = 1'b0;
      repeat (4) begin
        cyc(1);
        if (atqb === 1'b1) seen = 1'b1;
      end
      chk("atqb", 32'(tbl[i][8]), 32'(seen));
    end
  endtask : t_reqb

  // Command bytes: header, length, that many data bytes, expected length
  function automatic logic [7:0] cmd_byte(input int i, n);
    return (i == 4) ? 8'(n - 6) : 8'(i * 3 + 1);
  endfunction : cmd_byte

  task automatic push_cmd(input int n);
    for (int i = 0; i < n; i++) begin
      cvalid <= 1'b1;
      cdata <= cmd_byte(i, n);
      clast <= (i == n - 1);
      cyc(1);
      while (cready !== 1'b1) cyc(1);
    end
    cvalid <= 1'b0;
    cdata <= ~cdata;
  endtask : push_cmd

  task automatic pull_cmd(input int n);
    int k = 0;
    while (1) begin
      cyc(1);
      if (tcv === 1'b1 && cmd_rdy === 1'b1) begin
        chk("cmd byte", 32'(cmd_byte(k, n)), 32'(tcd));
        k++;
        if (tcl === 1'b1) break;
      end
    end
    chk("cmd count", n, k);
  endtask : pull_cmd

  task automatic feed_resp(input int n);
    for (int i = 0; i < n; i++) begin
      rvalid <= 1'b1;
      rdata <= 8'(i + 8'h40);
      rlast <= (i == n - 1);
      cyc(1);
      while ((trdy | trdy2) !== 1'b1) cyc(1);
    end
    rvalid <= 1'b0;
    rdata <= ~rdata;
  endtask : feed_resp

  task automatic pull_resp(input int n);
    int k = 0;
    while (1) begin
      cyc(1);
      if (rsp_v === 1'b1) begin
        chk("resp byte", 32'(8'(k + 8'h40)), 32'(rsp_d));
        k++;
        if (rsp_last === 1'b1) break;
      end
    end
    chk("resp count", n, k);
  endtask : pull_resp

  task automatic t_exchange(input int nc, nr);
    fork
      push_cmd(nc);
      pull_cmd(nc);
      feed_resp(nr);
      pull_resp(nr);
    join
  endtask : t_exchange

  task automatic t_deselect;
    while (busy !== 1'b0) cyc(1);
    desel <= 1'b1;
    cyc(1);
    desel <= 1'b0;
    cyc(2);
    while (busy !== 1'b0) cyc(1);
    cyc(2);
    chk("tag active", 0, 32'(active));
    chk("reader gave up", 0, 32'(fail));
  endtask : t_deselect

  // Sends one frame to the second tag and judges the reply head
  task automatic step(input logic [7:0] pcb, input int ninf, nrsp,
                      input logic [7:0] exp);
    logic [7:0] got;
    int k = 0;
    for (int i = 0; i <= ninf; i++) begin
      lk2.dn_valid <= 1'b1;
      lk2.dn_data <= (i == 0) ? pcb : 8'h5a;
      lk2.dn_last <= (i == ninf);
      cyc(1);
      while (lk2.dn_ready !== 1'b1) cyc(1);
    end
    lk2.dn_valid <= 1'b0;
    lk2.dn_last <= 1'b0;
    lk2.dn_data <= ~lk2.dn_data;
    if (nrsp > 0) feed_resp(nrsp);
    lk2.up_ready <= 1'b1;
    while (1) begin
      cyc(1);
      if (lk2.up_valid === 1'b1) begin
        if (k == 0) got = lk2.up_data;
        k++;
        if (lk2.up_last === 1'b1) break;
      end
    end
    lk2.up_ready <= 1'b0;
    chk("reply pcb", 32'(exp), 32'(got));
  endtask : step

  task automatic t_recovery;
    lk2.activate <= 1'b1;
    cyc(1);
    lk2.activate <= 1'b0;
    cyc(2);
    step(8'h02, 1, 2, 8'h02);
    step(8'hb2, 0, 0, 8'h02);
    step(8'hb3, 0, 0, 8'ha2);
    step(8'ha3, 0, 0, 8'hb2);
    step(8'hf2, 0, 0, 8'hb2);
    step(8'h03, 1, 2, 8'h03);
    step(8'h02, 1, 70, 8'h12);
    chk("tag chaining", 1, 32'(chain2));
    step(8'hf2, 0, 0, 8'ha2);
    step(8'ha3, 0, 0, 8'h03);
    step(8'hc2, 0, 0, 8'hc2);
  endtask : t_recovery

  initial begin
    {act, reqb, desel, cvalid, clast, rvalid, rlast} = 7'h00;
    rafi = 8'h00;
    cdata = 8'h00;
    rdata = 8'h00;
    sys_afi = 8'h35;
    lk2.activate = 1'b0;
    lk2.reqb_valid = 1'b0;
    lk2.reqb_afi = 8'h00;
    lk2.dn_valid = 1'b0;
    lk2.dn_last = 1'b0;
    lk2.dn_data = 8'h00;
    lk2.up_ready = 1'b0;
    cyc(6);
    rst_n_i <= 1'b1;
    t_reqb();
    act <= 1'b1;
    cyc(1);
    act <= 1'b0;
    cyc(2);
    t_exchange(7, 2);
    t_exchange(70, 70);
    t_exchange(64, 66);
    t_deselect();
    t_recovery();
    print_verdict();
  end

  // Hang guard
  initial begin
    cyc(20000);
    fail_count++;
    print_verdict();
  end
endmodule : testbench
